/* include/flash_host_pkg.sv */
// package: command codes, unlock addresses, bus timing and carrier types
package flash_host_pkg;
    // ---------------------------------------------------------------
    // command data codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_AUTOSEL = 8'h90;
    localparam logic [7:0] CMD_PROG = 8'hA0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    // ---------------------------------------------------------------
    // unlock addresses, word and byte mode
    // ---------------------------------------------------------------
    localparam logic [18:0] ADDR_W_FIRST = 19'h00555;
    localparam logic [18:0] ADDR_W_SECOND = 19'h002AA;
    localparam logic [18:0] ADDR_B_FIRST = 19'h00AAA;
    localparam logic [18:0] ADDR_B_SECOND = 19'h00555;
    localparam logic [18:0] ADDR_DONT_CARE = 19'h00000;
    // ---------------------------------------------------------------
    // sector select field of the word address
    // ---------------------------------------------------------------
    localparam int SECT_LSB = 12;
    localparam int SECT_MSB = 17;
    // ---------------------------------------------------------------
    // write strobe timing
    // ---------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int SETUP_NS = 50;
    localparam int PULSE_NS = 100;
    localparam int HOLD_NS = 50;
    localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] PULSE_CYC = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
    // ---------------------------------------------------------------
    // operations requested by the user
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_RESET = 3'h0,
        OP_AUTOSEL = 3'h1,
        OP_PROG = 3'h2,
        OP_CHIP_ERASE = 3'h3,
        OP_SECT_ERASE = 3'h4,
        OP_SUSPEND = 3'h5,
        OP_RESUME = 3'h6
    } op_e;
    // ---------------------------------------------------------------
    // carrier types
    // ---------------------------------------------------------------
    typedef struct packed {
        op_e op;
        logic [18:0] addr;
        logic [15:0] data;
    } req_s;
    typedef struct packed {
        logic [18:0] addr;
        logic [15:0] data;
    } bus_word_s;
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
    } strobe_s;
endpackage : flash_host_pkg

/* rtl/flash_write_cycle.sv */
// one bus write cycle on the flash strobes
`timescale 1ns/1ns
module flash_write_cycle (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // request
    input wire logic start_i,
    input flash_host_pkg::bus_word_s word_i,
    output logic busy_o,
    output logic done_o,
    // flash pins
    output flash_host_pkg::strobe_s strobe_o,
    output logic [18:0] addr_o,
    output logic [15:0] dq_o,
    output logic dq_oe_o
);
    // ---------------------------------------------------------------
    // phase machine
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_IDLE = 4'h1,
        PH_SETUP = 4'h2,
        PH_PULSE = 4'h4,
        PH_HOLD = 4'h8
    } phase_e;
    phase_e ph_q, ph_d;
    logic [3:0] cnt_q, cnt_d;
    flash_host_pkg::bus_word_s word_q, word_d;
    logic done_q, done_d;

    always_comb begin
        ph_d = ph_q;
        cnt_d = cnt_q;
        word_d = word_q;
        done_d = 1'b0;
        case (ph_q)
            PH_IDLE: begin
                if (start_i) begin
                    word_d = word_i;
                    cnt_d = flash_host_pkg::SETUP_CYC;
                    ph_d = PH_SETUP;
                end
            end
            PH_SETUP: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    cnt_d = flash_host_pkg::PULSE_CYC;
                    ph_d = PH_PULSE;
                end
            end
            PH_PULSE: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    cnt_d = flash_host_pkg::HOLD_CYC;
                    ph_d = PH_HOLD;
                end
            end
            PH_HOLD: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    done_d = 1'b1;
                    ph_d = PH_IDLE;
                end
            end
            default: ph_d = PH_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ph_q <= PH_IDLE;
            cnt_q <= 4'h0;
            word_q <= '0;
            done_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            word_q <= word_d;
            done_q <= done_d;
        end
    end

    // ---------------------------------------------------------------
    // pins: ce and we fall together, address set before the fall,
    // data held past the rise
    // ---------------------------------------------------------------
    assign busy_o = (ph_q != PH_IDLE);
    assign done_o = done_q;
    assign strobe_o.ce_n = (ph_q != PH_PULSE); // R11
    assign strobe_o.we_n = (ph_q != PH_PULSE); // R11
    assign strobe_o.oe_n = 1'b1;
    assign addr_o = word_q.addr;
    assign dq_o = word_q.data;
    assign dq_oe_o = (ph_q != PH_IDLE);
endmodule : flash_write_cycle

/* rtl/flash_cmd_host.sv */
// host controller issuing command sequences to a parallel nor flash
// Functional notes
// [R1] device picks the erased sector from sector select address bits only
// [R2] device reads array after power-up without any command
// [R3] in suspend, reads inside suspended sectors give status
// [R4] on time-limit failure host writes reset; device returns to read; fail_flag_i is unused, reset is sent only on an OP_RESET request
// [R5] reset command returns device to read; address ignored
// [R6] reset mid-sequence aborts; ignored once operation runs
// [R7] autoselect persists until host writes reset
// [R8] unlock, unlock, autoselect enters autoselect mode
// [R9] byte or word per program, chosen by width select pin
// [R10] program is four writes: two unlocks, setup, address and data
// [R11] address taken at later fall, data at earlier rise of strobes
// [R12] programming clears bits only; erase sets them
// [R13] time-limit failure flag stays set until reset
// [R14] chip erase is six writes ending with code 10
// [R15] embedded erase preprograms by itself
// [R16] all commands ignored during chip erase
// [R17] after erase device returns to read and drops latched address
// [R18] sector erase is six writes, last at sector address with 30
// [R19] during sector erase only suspend is accepted
// [R20] suspend only during sector erase; address ignored
// [R21] suspend halts erase in bounded time; other sectors usable
// [R22] autoselect rejected in suspend mode
// [R23] resume continues erase; extra resumes ignored
// [R24] wrong address, data or order aborts sequence to read
// [R25] single-cycle commands: reset F0, suspend B0, resume 30
// [R26] unlock AA at 555 then 55 at 2AA; byte mode AAA and 555
// [R27] third cycle 90, A0 or 80; sixth cycle 10 or 30
`timescale 1ns/1ns
module flash_cmd_host (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // user request
    input wire logic req_valid_i,
    input flash_host_pkg::req_s req_i,
    output logic req_ready_o,
    output logic req_refused_o,
    // mode tracking
    input wire logic byte_mode_i,
    input wire logic erase_done_i,
    input wire logic fail_flag_i,
    output logic autosel_mode_o,
    output logic suspend_mode_o,
    output logic erasing_o,
    output logic sect_erase_o,
    // flash pins
    output flash_host_pkg::strobe_s strobe_o,
    output logic [18:0] addr_o,
    output logic [15:0] dq_o,
    output logic dq_oe_o,
    output logic byte_n_o
);
    // ---------------------------------------------------------------
    // sequencer state
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_ISSUE = 3'h2,
        S_WAIT = 3'h4
    } seq_e;
    typedef enum logic [3:0] {
        M_READ = 4'h1,
        M_AUTOSEL = 4'h2,
        M_CHIP_ER = 4'h4,
        M_SECT_ER = 4'h8
    } mode_e;
    seq_e st_q, st_d;
    mode_e mode_q, mode_d;
    logic susp_q, susp_d;
    flash_host_pkg::req_s cur_q, cur_d;
    logic [2:0] idx_q, idx_d;
    logic [2:0] len_q, len_d;
    logic refused_q, refused_d;
    logic start;
    logic cyc_done;
    flash_host_pkg::bus_word_s word;
    logic [18:0] a_first;
    logic [18:0] a_second;
    logic accept;

    // R26
    assign a_first = byte_mode_i ? flash_host_pkg::ADDR_B_FIRST
                                 : flash_host_pkg::ADDR_W_FIRST;
    assign a_second = byte_mode_i ? flash_host_pkg::ADDR_B_SECOND
                                  : flash_host_pkg::ADDR_W_SECOND;

    // ---------------------------------------------------------------
    // which requests the flash would honour in its present mode
    // ---------------------------------------------------------------
    always_comb begin
        accept = 1'b0;
        case (req_i.op)
            flash_host_pkg::OP_RESET:
                accept = (mode_q != M_CHIP_ER) && !(mode_q == M_SECT_ER
                         && !susp_q); // R6 R16 R19
            flash_host_pkg::OP_AUTOSEL:
                accept = (mode_q == M_READ) && !susp_q; // R22
            flash_host_pkg::OP_PROG:
                accept = (mode_q == M_READ) || susp_q; // R21
            flash_host_pkg::OP_CHIP_ERASE,
            flash_host_pkg::OP_SECT_ERASE:
                accept = (mode_q == M_READ) && !susp_q;
            flash_host_pkg::OP_SUSPEND:
                accept = (mode_q == M_SECT_ER) && !susp_q; // R20
            flash_host_pkg::OP_RESUME:
                accept = susp_q && (mode_q == M_SECT_ER); // R23
            default: accept = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // bus word for each cycle of the sequence
    // ---------------------------------------------------------------
    always_comb begin
        word.addr = a_first;
        word.data = {8'h00, flash_host_pkg::CMD_UNLOCK1};
        case (idx_q)
            3'h0: begin
                if (len_q == 3'h1) begin
                    word.addr = flash_host_pkg::ADDR_DONT_CARE; // R5 R25
                    word.data = cur_q.data;
                end
            end
            3'h1, 3'h4: begin
                word.addr = a_second;
                word.data = {8'h00, flash_host_pkg::CMD_UNLOCK2};
            end
            3'h2: begin
                case (cur_q.op) // R27
                    flash_host_pkg::OP_AUTOSEL:
                        word.data = {8'h00, flash_host_pkg::CMD_AUTOSEL};
                    flash_host_pkg::OP_PROG:
                        word.data = {8'h00, flash_host_pkg::CMD_PROG};
                    default:
                        word.data = {8'h00, flash_host_pkg::CMD_ERASE_SETUP};
                endcase
            end
            3'h3: begin
                if (cur_q.op == flash_host_pkg::OP_PROG) begin
                    word.addr = cur_q.addr; // R10 R9
                    word.data = byte_mode_i ? {8'h00, cur_q.data[7:0]}
                                            : cur_q.data;
                end
            end
            3'h5: begin
                if (cur_q.op == flash_host_pkg::OP_SECT_ERASE) begin
                    word.addr = '0;
                    word.addr[flash_host_pkg::SECT_MSB:
                              flash_host_pkg::SECT_LSB] =
                        cur_q.addr[flash_host_pkg::SECT_MSB:
                                   flash_host_pkg::SECT_LSB]; // R1 R18
                    word.data = {8'h00, flash_host_pkg::CMD_SECT_ERASE};
                end else begin
                    word.data = {8'h00, flash_host_pkg::CMD_CHIP_ERASE};
                end // R14
            end
            default: word.addr = a_first;
        endcase
    end

    // ---------------------------------------------------------------
    // sequencer and mode tracking
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        mode_d = mode_q;
        susp_d = susp_q;
        cur_d = cur_q;
        idx_d = idx_q;
        len_d = len_q;
        refused_d = 1'b0;
        start = 1'b0;
        if (erase_done_i && (mode_q == M_CHIP_ER || mode_q == M_SECT_ER)
            && !susp_q) begin
            mode_d = M_READ; // R17
        end
        case (st_q)
            S_IDLE: begin
                if (req_valid_i) begin
                    if (accept) begin
                        cur_d = req_i;
                        idx_d = 3'h0;
                        st_d = S_ISSUE;
                        case (req_i.op)
                            flash_host_pkg::OP_AUTOSEL: len_d = 3'h3;
                            flash_host_pkg::OP_PROG: len_d = 3'h4;
                            flash_host_pkg::OP_CHIP_ERASE,
                            flash_host_pkg::OP_SECT_ERASE: len_d = 3'h6;
                            default: len_d = 3'h1;
                        endcase
                        if (req_i.op == flash_host_pkg::OP_RESET ||
                            req_i.op == flash_host_pkg::OP_SUSPEND ||
                            req_i.op == flash_host_pkg::OP_RESUME) begin
                            cur_d.data = {8'h00,
                                (req_i.op == flash_host_pkg::OP_RESET) ?
                                    flash_host_pkg::CMD_RESET :
                                (req_i.op == flash_host_pkg::OP_SUSPEND) ?
                                    flash_host_pkg::CMD_SUSPEND :
                                    flash_host_pkg::CMD_RESUME}; // R25
                        end
                    end else begin
                        refused_d = 1'b1; // R24
                    end
                end
            end
            S_ISSUE: begin
                start = 1'b1;
                st_d = S_WAIT;
            end
            S_WAIT: begin
                if (cyc_done) begin
                    if (idx_q == len_q - 3'h1) begin
                        st_d = S_IDLE;
                        case (cur_q.op)
                            flash_host_pkg::OP_RESET: begin
                                mode_d = M_READ; // R4 R7 R13
                                susp_d = 1'b0;
                            end
                            flash_host_pkg::OP_AUTOSEL:
                                mode_d = M_AUTOSEL; // R8
                            flash_host_pkg::OP_CHIP_ERASE:
                                mode_d = M_CHIP_ER; // R15 R16
                            flash_host_pkg::OP_SECT_ERASE:
                                mode_d = M_SECT_ER; // R19
                            flash_host_pkg::OP_SUSPEND:
                                susp_d = 1'b1; // R3 R21
                            flash_host_pkg::OP_RESUME:
                                susp_d = 1'b0; // R23
                            default: mode_d = mode_d; // R12
                        endcase
                    end else begin
                        idx_d = idx_q + 3'h1;
                        st_d = S_ISSUE;
                    end
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= S_IDLE;
            mode_q <= M_READ; // R2
            susp_q <= 1'b0;
            cur_q <= '0;
            idx_q <= 3'h0;
            len_q <= 3'h1;
            refused_q <= 1'b0;
        end else begin
            st_q <= st_d;
            mode_q <= mode_d;
            susp_q <= susp_d;
            cur_q <= cur_d;
            idx_q <= idx_d;
            len_q <= len_d;
            refused_q <= refused_d;
        end
    end

    // ---------------------------------------------------------------
    // single bus cycle engine
    // ---------------------------------------------------------------
    flash_write_cycle flash_write_cycle_inst (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .start_i(start),
        .word_i(word),
        .busy_o(),
        .done_o(cyc_done),
        .strobe_o(strobe_o),
        .addr_o(addr_o),
        .dq_o(dq_o),
        .dq_oe_o(dq_oe_o)
    );

    assign req_ready_o = (st_q == S_IDLE);
    assign req_refused_o = refused_q;
    assign autosel_mode_o = (mode_q == M_AUTOSEL);
    assign suspend_mode_o = susp_q;
    assign erasing_o = (mode_q == M_CHIP_ER) || (mode_q == M_SECT_ER);
    assign sect_erase_o = (mode_q == M_SECT_ER);
    assign byte_n_o = !byte_mode_i; // R9
endmodule : flash_cmd_host

/* bench/flash_cmd_host_chk.sv */
// checker: timing and refusal relations at the host controller ports
`timescale 1ns/1ns
module flash_cmd_host_chk (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // request and modes
    input wire logic req_valid_i,
    input flash_host_pkg::req_s req_i,
    input wire logic req_ready_o,
    input wire logic req_refused_o,
    input wire logic byte_mode_i,
    input wire logic suspend_mode_o,
    input wire logic erasing_o,
    input wire logic sect_erase_o,
    // flash pins
    input flash_host_pkg::strobe_s strobe_o,
    input wire logic [18:0] addr_o,
    input wire logic [15:0] dq_o,
    input wire logic dq_oe_o,
    input wire logic byte_n_o
);
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic take;
    assign take = req_valid_i && req_ready_o;
    AST_OE_HIGH: assert property (strobe_o.oe_n)
        else $error("output enable strobe went low");
    AST_CE_WE: assert property (strobe_o.ce_n == strobe_o.we_n)
        else $error("chip and write enable differ");
    AST_PULSE: assert property ($fell(strobe_o.we_n) |=>
        !strobe_o.we_n ##1 strobe_o.we_n)
        else $error("write pulse not two cycles");
    AST_STABLE: assert property (!strobe_o.we_n |->
        $stable(addr_o) && $stable(dq_o) && dq_oe_o)
        else $error("address or data moved in pulse");
    AST_WIDTH: assert property (byte_n_o == !byte_mode_i)
        else $error("width select pin wrong");
    AST_RESUME: assert property (take && !suspend_mode_o &&
        req_i.op == flash_host_pkg::OP_RESUME |=> req_refused_o)
        else $error("resume outside suspend not refused");
    AST_AUTOSEL: assert property (take && suspend_mode_o &&
        req_i.op == flash_host_pkg::OP_AUTOSEL |=> req_refused_o)
        else $error("autoselect in suspend not refused");
    AST_SUSPEND: assert property (take &&
        req_i.op == flash_host_pkg::OP_SUSPEND &&
        !(erasing_o && sect_erase_o && !suspend_mode_o) |=> req_refused_o)
        else $error("suspend outside sector erase not refused");
    AST_CHIP: assert property (take && erasing_o && !sect_erase_o &&
        req_i.op == flash_host_pkg::OP_RESET |=> req_refused_o)
        else $error("reset during chip erase not refused");
endmodule : flash_cmd_host_chk

/* bench/flash_dev_model.sv */
// behavioural flash device decoding the host write cycles
`timescale 1ns/1ns
module flash_dev_model (
    // flash pins
    input flash_host_pkg::strobe_s strobe_i,
    input wire logic [18:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic byte_n_i,
    // decoded results
    output flash_host_pkg::op_e last_op_o,
    output logic [18:0] last_addr_o,
    output logic [15:0] last_data_o,
    output logic [5:0] sector_o,
    output logic autosel_o,
    output int ops_o,
    output int errs_o
);
    // ---------------------------------------------------------------
    // command decoder
    // ---------------------------------------------------------------
    logic [18:0] lat;
    logic [18:0] a1;
    logic [18:0] a2;
    logic [7:0] d;
    logic prog;
    logic wr = 1'b0;
    int step;
    assign a1 = byte_n_i ? 19'h00555 : 19'h00AAA;
    assign a2 = byte_n_i ? 19'h002AA : 19'h00555;
    initial begin
        last_op_o = flash_host_pkg::OP_RESET;
        {lat, last_addr_o, last_data_o, sector_o, autosel_o} = '0;
        {ops_o, errs_o, step, prog} = '0;
    end
    task automatic done(input flash_host_pkg::op_e op);
        last_op_o = op;
        last_addr_o = lat;
        last_data_o = dq_i;
        sector_o = lat[17:12];
        if (op == flash_host_pkg::OP_AUTOSEL) autosel_o = 1'b1;
        if (op == flash_host_pkg::OP_RESET) autosel_o = 1'b0;
        ops_o++;
        step = 0;
    endtask : done
    always @(strobe_i) begin
        if (!strobe_i.ce_n && !strobe_i.we_n && strobe_i.oe_n) begin
            if (!wr) lat = addr_i;
            wr = 1'b1;
        end else wr = 1'b0;
    end
    always @(negedge wr) begin
        d = dq_i[7:0];
        if (step == 3 && prog) done(flash_host_pkg::OP_PROG);
        else if (d == 8'hF0) done(flash_host_pkg::OP_RESET);
        else if (step == 0 && lat == a1 && d == 8'hAA) step = 1;
        else if (step == 1 && lat == a2 && d == 8'h55) step = 2;
        else if (step == 2 && lat == a1 && d == 8'h90)
            done(flash_host_pkg::OP_AUTOSEL);
        else if (step == 2 && lat == a1 && d == 8'hA0) begin
            prog = 1'b1;
            step = 3;
        end else if (step == 2 && lat == a1 && d == 8'h80) begin
            prog = 1'b0;
            step = 3;
        end else if (step == 3 && lat == a1 && d == 8'hAA) step = 4;
        else if (step == 4 && lat == a2 && d == 8'h55) step = 5;
        else if (step == 5 && lat == a1 && d == 8'h10)
            done(flash_host_pkg::OP_CHIP_ERASE);
        else if (step == 5 && d == 8'h30)
            done(flash_host_pkg::OP_SECT_ERASE);
        else if (step == 0 && d == 8'hB0) done(flash_host_pkg::OP_SUSPEND);
        else if (step == 0 && d == 8'h30) done(flash_host_pkg::OP_RESUME);
        else begin
            errs_o++;
            step = 0;
        end
    end
endmodule : flash_dev_model

/* bench/tb_flash_cmd_host.sv */
// testbench: command sequences, refusals and modes of the host controller
`timescale 1ns/1ns
module tb_flash_cmd_host;
    // ---------------------------------------------------------------
    // signals and instances
    // ---------------------------------------------------------------
    logic clock_i = 0;
    logic sys_rst_i = 1;
    logic req_valid_i = 0;
    flash_host_pkg::req_s req_i = '0;
    logic byte_mode_i = 0;
    logic erase_done_i = 0;
    logic fail_flag_i = 0;
    logic req_ready_o, req_refused_o, autosel_mode_o, suspend_mode_o;
    logic erasing_o, sect_erase_o, dq_oe_o, byte_n_o;
    flash_host_pkg::strobe_s strobe_o;
    logic [18:0] addr_o, last_addr;
    logic [15:0] dq_o, last_data;
    logic [5:0] sector;
    logic autosel;
    flash_host_pkg::op_e last_op;
    int ops, errs, fails = 0, cmp_count = 0, cyc = 0;
    flash_cmd_host flash_cmd_host_inst (.clock_i, .sys_rst_i, .req_valid_i,
        .req_i, .req_ready_o, .req_refused_o, .byte_mode_i, .erase_done_i,
        .fail_flag_i, .autosel_mode_o, .suspend_mode_o, .erasing_o,
        .sect_erase_o, .strobe_o, .addr_o, .dq_o, .dq_oe_o, .byte_n_o);
    flash_dev_model flash_dev_model_inst (.strobe_i(strobe_o), .addr_i(addr_o),
        .dq_i(dq_o), .byte_n_i(byte_n_o), .last_op_o(last_op),
        .last_addr_o(last_addr), .last_data_o(last_data), .sector_o(sector),
        .autosel_o(autosel), .ops_o(ops), .errs_o(errs));
    initial begin
        forever #25 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            conclude();
        end
    end
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : check
    task automatic step;
        @(posedge clock_i);
        #5;
    endtask : step
    task automatic issue(input flash_host_pkg::op_e op, input logic [18:0] a,
        input logic [15:0] dt, input logic exp_ref);
        int n0;
        logic seen;
        n0 = ops;
        req_i = '{op, a, dt};
        req_valid_i = 1;
        step();
        req_valid_i = 0;
        seen = req_refused_o;
        step();
        seen = seen | req_refused_o;
        for (int i = 0; i < 200 && req_ready_o !== 1'b1; i++) step();
        check(seen === exp_ref, "refusal wrong");
        if (exp_ref) check(ops == n0, "refused request reached bus");
        else check(ops == n0 + 1 && last_op === op && errs == 0, "decode");
    endtask : issue
    task automatic t_program;
        issue(flash_host_pkg::OP_PROG, 19'h01234, 16'h5A5A, 0);
        check(last_addr === 19'h01234 && last_data === 16'h5A5A, "word");
        byte_mode_i = 1;
        issue(flash_host_pkg::OP_PROG, 19'h00077, 16'h0033, 0);
        check(last_data[7:0] === 8'h33, "byte program value");
        byte_mode_i = 0;
        fail_flag_i = 1;
        issue(flash_host_pkg::OP_RESET, 19'h00000, 16'h00F0, 0);
        fail_flag_i = 0;
    endtask : t_program
    task automatic t_autosel;
        issue(flash_host_pkg::OP_AUTOSEL, 19'h0, 16'h0, 0);
        check(autosel_mode_o === 1'b1 && autosel === 1'b1, "autosel");
        issue(flash_host_pkg::OP_PROG, 19'h00100, 16'h1111, 1);
        issue(flash_host_pkg::OP_RESET, 19'h0, 16'h0, 0);
        check(autosel_mode_o === 1'b0 && autosel === 1'b0, "autosel exit");
    endtask : t_autosel
    task automatic t_chip;
        issue(flash_host_pkg::OP_CHIP_ERASE, 19'h0, 16'h0, 0);
        check(erasing_o === 1'b1 && sect_erase_o === 1'b0, "chip");
        issue(flash_host_pkg::OP_RESET, 19'h0, 16'h0, 1);
        issue(flash_host_pkg::OP_SUSPEND, 19'h0, 16'h0, 1);
        erase_done_i = 1;
        step();
        erase_done_i = 0;
        step();
        check(erasing_o === 1'b0, "chip erase end");
    endtask : t_chip
    task automatic t_sector;
        issue(flash_host_pkg::OP_SECT_ERASE, 19'h3F123, 16'h0, 0);
        check(sector === 6'h3F && sect_erase_o === 1'b1, "sector");
        issue(flash_host_pkg::OP_AUTOSEL, 19'h0, 16'h0, 1);
        issue(flash_host_pkg::OP_RESET, 19'h0, 16'h0, 1);
        issue(flash_host_pkg::OP_SUSPEND, 19'h00ABC, 16'h0, 0);
        check(suspend_mode_o === 1'b1, "suspend");
        issue(flash_host_pkg::OP_AUTOSEL, 19'h0, 16'h0, 1);
        issue(flash_host_pkg::OP_PROG, 19'h01000, 16'h00C3, 0);
        issue(flash_host_pkg::OP_RESUME, 19'h0, 16'h0, 0);
        issue(flash_host_pkg::OP_RESUME, 19'h0, 16'h0, 1);
        issue(flash_host_pkg::OP_SUSPEND, 19'h0, 16'h0, 0);
        issue(flash_host_pkg::OP_RESUME, 19'h0, 16'h0, 0);
        erase_done_i = 1;
        step();
        erase_done_i = 0;
        step();
        check(erasing_o === 1'b0 && suspend_mode_o === 1'b0, "end");
    endtask : t_sector
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock_i);
        #5;
        sys_rst_i = 0;
        check(req_ready_o === 1'b1 && autosel_mode_o === 1'b0, "reset");
        t_program();
        t_autosel();
        t_chip();
        t_sector();
        conclude();
    end
endmodule : tb_flash_cmd_host
bind flash_cmd_host flash_cmd_host_chk flash_cmd_host_chk_inst (.clock_i,
    .sys_rst_i, .req_valid_i, .req_i, .req_ready_o, .req_refused_o,
    .byte_mode_i, .suspend_mode_o, .erasing_o, .sect_erase_o, .strobe_o,
    .addr_o, .dq_o, .dq_oe_o, .byte_n_o);
